/* verilog/oam_exec.sv */
// Behaviour
// RQ1: top nibble 1101 decodes as OR with eight-bit literal.
// RQ2: literal OR result goes to work register and sets zero flag.
// RQ3: 0001 00df ffff is OR of work with addressed file register.
// RQ4: OR with file writes work when d is 0, file when 1.
// RQ5: 0010 00df ffff copies addressed file register to destination.
// RQ6: copy writes work when d is 0, same file register when 1.
// RQ7: copy updates zero flag from moved value for both destinations.
// RQ8: top nibble 1100 loads literal to work, flags kept; one cycle each.
`timescale 1ns/1ps
module oam_exec
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic ce,
   input wire logic instr_valid,
   input wire logic [oam_pkg::WORD_W-1:0] instr_word,
   output logic instr_ready,
   output logic [oam_pkg::DATA_W-1:0] work_value,
   output logic zero_flag,
   output logic done
);
   import oam_pkg::*;

   // two-phase: fetch operand from memory, then execute
   typedef enum logic [1:0]
   {
      ST_IDLE = 2'h1,
      ST_EXEC = 2'h2
   } oam_state_type;

   oam_file_if fif ();
   oam_state_type state_reg;
   logic [WORD_W-1:0] word_reg;
   logic [7:0] work_reg;
   logic zero_reg;
   logic done_reg;
   oam_op_type op;
   logic [7:0] result;
   logic to_file;
   logic hits_zero;

   oam_file_mem u_mem
   (
      .clk(clk),
      .ce(ce),
      .fif(fif)
   );

   assign instr_ready = (state_reg == ST_IDLE);
   assign fif.rd_addr = instr_word[ADDR_W-1:0];
   assign op = oam_decode(word_reg);

   always_comb
   begin
      result = fif.rd_data;
      to_file = 1'b0;
      hits_zero = 1'b0;
      case (op)
         OP_OR_LITERAL_INTO_WORK:
         begin
            result = work_reg | word_reg[7:0]; // see RQ1
            hits_zero = 1'b1;
         end
         OP_OR_WORK_WITH_FILE:
         begin
            result = work_reg | fif.rd_data; // see RQ3
            to_file = word_reg[DEST_BIT]; // see RQ4
            hits_zero = 1'b1;
         end
         OP_COPY_FILE_REGISTER:
         begin
            result = fif.rd_data; // see RQ5
            to_file = word_reg[DEST_BIT]; // see RQ6
            hits_zero = 1'b1; // see RQ7
         end
         OP_LOAD_LITERAL_TO_WORK:
         begin
            result = word_reg[7:0]; // see RQ8
         end
         default:
         begin
            result = fif.rd_data;
         end
      endcase
   end

   assign fif.wr_en = ce && state_reg == ST_EXEC && to_file; // see RQ4
   assign fif.wr_addr = word_reg[ADDR_W-1:0];
   assign fif.wr_data = result;

   // sequencing
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         state_reg <= ST_IDLE;
         word_reg <= '0;
      end
      else if (ce)
      begin
         case (state_reg)
            ST_IDLE:
               if (instr_valid)
               begin
                  word_reg <= instr_word;
                  state_reg <= ST_EXEC;
               end
            ST_EXEC:
               state_reg <= ST_IDLE;
            default:
               state_reg <= ST_IDLE;
         endcase
      end
   end

   // work register and zero flag
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         work_reg <= WORK_RESET;
         zero_reg <= ZERO_RESET;
         done_reg <= 1'b0;
      end
      else if (ce)
      begin
         done_reg <= (state_reg == ST_EXEC);
         if (state_reg == ST_EXEC)
         begin
            if (op != OP_NONE && !to_file)
               work_reg <= result; // see RQ2
            if (hits_zero)
               zero_reg <= (result == 8'h00); // see RQ7
         end
      end
   end

   assign work_value = work_reg;
   assign zero_flag = zero_reg;
   assign done = done_reg;

   // literal operations
   chk_load_keeps_zero: assert property (@(posedge clk) disable iff (sys_rst)
      ce && state_reg == ST_EXEC && op == OP_LOAD_LITERAL_TO_WORK
      |=> $stable(zero_reg) && work_reg == $past(word_reg[7:0]))
      else $error("load literal changed flag or missed work"); // see RQ8

   chk_or_lit_work: assert property (@(posedge clk) disable iff (sys_rst)
      ce && state_reg == ST_EXEC && op == OP_OR_LITERAL_INTO_WORK
      |=> work_reg == ($past(work_reg) | $past(word_reg[7:0]))
      && zero_reg == (work_reg == 8'h00))
      else $error("or literal result wrong"); // see RQ2

   // decoding
   chk_or_lit_decode: assert property (@(posedge clk) disable iff (sys_rst)
      word_reg[11:8] == OP_OR_LIT |-> op == OP_OR_LITERAL_INTO_WORK)
      else $error("or literal not decoded"); // see RQ1

   chk_load_decode: assert property (@(posedge clk) disable iff (sys_rst)
      word_reg[11:8] == OP_LOAD_LIT |-> op == OP_LOAD_LITERAL_TO_WORK)
      else $error("load literal not decoded"); // see RQ8

   chk_or_file_decode: assert property (@(posedge clk) disable iff (sys_rst)
      word_reg[11:6] == OP_OR_FILE |-> op == OP_OR_WORK_WITH_FILE)
      else $error("or file not decoded"); // see RQ3

   chk_copy_decode: assert property (@(posedge clk) disable iff (sys_rst)
      word_reg[11:6] == OP_COPY_FILE |-> op == OP_COPY_FILE_REGISTER)
      else $error("copy not decoded"); // see RQ5

   chk_unknown_keeps: assert property (@(posedge clk) disable iff (sys_rst)
      ce && state_reg == ST_EXEC && op == OP_NONE
      |=> $stable(work_reg) && $stable(zero_reg) && !$past(fif.wr_en))
      else $error("unknown word changed state"); // see RQ1

   // file operations
   chk_or_file_dest: assert property (@(posedge clk) disable iff (sys_rst)
      ce && state_reg == ST_EXEC && op == OP_OR_WORK_WITH_FILE
      |-> fif.wr_en == word_reg[DEST_BIT]
      && fif.wr_data == (work_reg | fif.rd_data))
      else $error("or file destination wrong"); // see RQ4

   chk_or_file_work: assert property (@(posedge clk) disable iff (sys_rst)
      ce && state_reg == ST_EXEC && op == OP_OR_WORK_WITH_FILE
      && !word_reg[DEST_BIT]
      |=> work_reg == ($past(work_reg) | $past(fif.rd_data)))
      else $error("or file to work wrong"); // see RQ4

   chk_or_file_zero: assert property (@(posedge clk) disable iff (sys_rst)
      ce && state_reg == ST_EXEC && op == OP_OR_WORK_WITH_FILE
      |=> zero_reg == ($past(result) == 8'h00))
      else $error("or file zero flag wrong"); // see RQ3

   chk_copy_dest: assert property (@(posedge clk) disable iff (sys_rst)
      ce && state_reg == ST_EXEC && op == OP_COPY_FILE_REGISTER
      && !word_reg[DEST_BIT]
      |=> work_reg == $past(fif.rd_data) && !$past(fif.wr_en))
      else $error("copy to work wrong"); // see RQ6

   chk_copy_file_write: assert property (@(posedge clk) disable iff (sys_rst)
      ce && state_reg == ST_EXEC && op == OP_COPY_FILE_REGISTER
      && word_reg[DEST_BIT]
      |-> fif.wr_en && fif.wr_addr == word_reg[ADDR_W-1:0]
      && fif.wr_data == fif.rd_data)
      else $error("copy to file wrong"); // see RQ6

   // sequencing and copy zero flag
   chk_take_word: assert property (@(posedge clk) disable iff (sys_rst)
      ce && instr_valid && instr_ready
      |=> state_reg == ST_EXEC && word_reg == $past(instr_word))
      else $error("offered word not taken"); // see RQ8

   chk_one_cycle: assert property (@(posedge clk) disable iff (sys_rst)
      ce && state_reg == ST_EXEC |=> state_reg == ST_IDLE && done)
      else $error("execute did not finish in one cycle"); // see RQ8

   chk_freeze: assert property (@(posedge clk) disable iff (sys_rst)
      !ce |=> $stable(work_reg) && $stable(zero_reg) && $stable(state_reg))
      else $error("state moved while clock enable low"); // see RQ8

   chk_copy_zero: assert property (@(posedge clk) disable iff (sys_rst)
      ce && state_reg == ST_EXEC && op == OP_COPY_FILE_REGISTER
      |=> zero_reg == ($past(fif.rd_data) == 8'h00))
      else $error("copy zero flag wrong"); // see RQ7
endmodule : oam_exec

/* verilog/oam_pkg.sv */
package oam_pkg;
   localparam int WORD_W = 12;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 5;
   localparam int DEST_BIT = 5;
   localparam logic [3:0] OP_OR_LIT = 4'hD;
   localparam logic [3:0] OP_LOAD_LIT = 4'hC;
   localparam logic [5:0] OP_OR_FILE = 6'h04;
   localparam logic [5:0] OP_COPY_FILE = 6'h08;
   localparam logic [7:0] WORK_RESET = 8'h00;
   localparam logic ZERO_RESET = 1'b0;
   localparam int FILE_DEPTH = 32;

   typedef enum logic [4:0]
   {
      OP_NONE = 5'h01,
      OP_OR_LITERAL_INTO_WORK = 5'h02,
      OP_OR_WORK_WITH_FILE = 5'h04,
      OP_COPY_FILE_REGISTER = 5'h08,
      OP_LOAD_LITERAL_TO_WORK = 5'h10
   } oam_op_type;

   function automatic oam_op_type oam_decode(input logic [11:0] word);
      oam_op_type op;
      op = OP_NONE;
      if (word[11:8] == OP_OR_LIT)
         op = OP_OR_LITERAL_INTO_WORK;
      else if (word[11:8] == OP_LOAD_LIT)
         op = OP_LOAD_LITERAL_TO_WORK;
      else if (word[11:6] == OP_OR_FILE)
         op = OP_OR_WORK_WITH_FILE;
      else if (word[11:6] == OP_COPY_FILE)
         op = OP_COPY_FILE_REGISTER;
      return op;
   endfunction : oam_decode
endpackage : oam_pkg

/* verilog/oam_file_if.sv */
`timescale 1ns/1ps
interface oam_file_if;
   logic [4:0] rd_addr;
   logic [7:0] rd_data;
   logic wr_en;
   logic [4:0] wr_addr;
   logic [7:0] wr_data;
   modport core (output rd_addr, input rd_data, output wr_en, wr_addr,
      wr_data);
   modport mem (input rd_addr, output rd_data, input wr_en, wr_addr,
      wr_data);
endinterface : oam_file_if

/* verilog/oam_file_mem.sv */
`timescale 1ns/1ps
module oam_file_mem
(
   input wire logic clk,
   input wire logic ce,
   oam_file_if.mem fif
);
   import oam_pkg::*;
   logic [7:0] mem_reg [FILE_DEPTH];
   logic [7:0] rd_reg;

   // registered read, write on same edge
   always_ff @(posedge clk)
   begin
      if (ce)
      begin
         if (fif.wr_en)
            mem_reg[fif.wr_addr] <= fif.wr_data;
         rd_reg <= mem_reg[fif.rd_addr];
      end
   end
   assign fif.rd_data = rd_reg;
endmodule : oam_file_mem

/* sim/or_and_move_instruction_exec_tb.sv */
`timescale 1ns/1ps
module or_and_move_instruction_exec_tb;
   import oam_pkg::*;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic ce = 1'b1;
   logic instr_valid = 1'b0;
   logic [WORD_W-1:0] instr_word = 12'h000;
   logic instr_ready;
   logic [DATA_W-1:0] work_value;
   logic zero_flag;
   logic done;
   int n_mismatch = 0;
   int n_checks = 0;

   oam_exec dut
   (
      .clk(clk),
      .sys_rst(sys_rst),
      .ce(ce),
      .instr_valid(instr_valid),
      .instr_word(instr_word),
      .instr_ready(instr_ready),
      .work_value(work_value),
      .zero_flag(zero_flag),
      .done(done)
   );

   initial
   begin
      forever #50 clk = ~clk;
   end

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : report_and_stop

   task automatic check8(input string what, input logic [7:0] exp,
      input logic [7:0] got);
      n_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : check8

   task automatic check1(input string what, input logic exp,
      input logic got);
      check8(what, {7'h00, exp}, {7'h00, got});
   endtask : check1

   // offer one word, wait for take and for the done pulse
   task automatic exec(input logic [11:0] w);
      int i;
      instr_valid <= 1'b1;
      instr_word <= w;
      @(negedge clk);
      for (i = 0; i < 8 && instr_ready !== 1'b1; i++)
         @(negedge clk);
      @(posedge clk);
      instr_valid <= 1'b0;
      for (i = 0; i < 8 && done !== 1'b1; i++)
         @(negedge clk);
      if (done !== 1'b1)
      begin
         n_mismatch++;
         report_and_stop();
      end
      @(posedge clk);
   endtask : exec

   task automatic run(input logic [11:0] w, input logic [7:0] ew,
      input logic ez);
      exec(w);
      check8("work_value", ew, work_value);
      check1("zero_flag", ez, zero_flag);
   endtask : run

   task automatic sc_reset;
      check8("work_value", WORK_RESET, work_value);
      check1("zero_flag", ZERO_RESET, zero_flag);
      check1("instr_ready", 1'b1, instr_ready);
   endtask : sc_reset

   task automatic sc_literals;
      run(12'hC00, 8'h00, 1'b0);
      run(12'hD00, 8'h00, 1'b1);
      run(12'hC9A, 8'h9A, 1'b1);
      run(12'hD35, 8'hBF, 1'b0);
   endtask : sc_literals

   // all-ones work makes file 31 known despite unreset memory
   task automatic sc_or_file;
      run(12'hCFF, 8'hFF, 1'b0);
      run(12'h13F, 8'hFF, 1'b0);
      run(12'hC00, 8'h00, 1'b0);
      run(12'hD00, 8'h00, 1'b1);
      run(12'h11F, 8'hFF, 1'b0);
   endtask : sc_or_file

   task automatic sc_copy;
      run(12'hC00, 8'h00, 1'b0);
      run(12'hD00, 8'h00, 1'b1);
      run(12'h23F, 8'h00, 1'b0);
      run(12'hD00, 8'h00, 1'b1);
      run(12'h21F, 8'hFF, 1'b0);
   endtask : sc_copy

   // near-miss encodings leave state alone
   task automatic sc_other;
      run(12'h140, 8'hFF, 1'b0);
      run(12'h260, 8'hFF, 1'b0);
      run(12'hE00, 8'hFF, 1'b0);
   endtask : sc_other

   // clock enable low freezes a pending word
   task automatic sc_freeze;
      ce <= 1'b0;
      instr_valid <= 1'b1;
      instr_word <= 12'hC55;
      repeat (3) @(posedge clk);
      check8("work_value", 8'hFF, work_value);
      check1("instr_ready", 1'b1, instr_ready);
      instr_valid <= 1'b0;
      ce <= 1'b1;
      @(posedge clk);
      check8("work_value", 8'hFF, work_value);
      check1("zero_flag", 1'b0, zero_flag);
   endtask : sc_freeze

   initial
   begin
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      sc_reset();
      sc_literals();
      sc_or_file();
      sc_copy();
      sc_other();
      sc_freeze();
      sys_rst <= 1'b1;
      @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      sc_reset();
      report_and_stop();
   end
endmodule : or_and_move_instruction_exec_tb
